// File: core/fsb_cfg.svh
// Constants for the first set bit finder: field layout, reset values and pipeline timing.
`ifndef FSB_CFG_SVH
`define FSB_CFG_SVH

`define FSB_FIELD_W 16
`define FSB_WORD_W 32
`define FSB_SHIFT_W 5
`define FSB_LOCK_BIT 8
`define FSB_INDEX_HI 7
`define FSB_INDEX_LO 4
`define FSB_POS_HI 3
`define FSB_POS_LO 0
`define FSB_RESULT_RESET 32'h0000_0000
`define FSB_COUNT_RESET 4'h0
`define FSB_MIN_GAP_INSTR 3

`endif

// File: core/fsb_pkg.sv
// Types shared by the first set bit finder modules.
package fsb_pkg;
	typedef logic [3:0] fsb_pos_t;
	typedef logic [3:0] fsb_count_t;
	typedef logic [31:0] fsb_word_t;

	typedef enum logic [1:0] {
		FSB_FETCH_NONE = 2'b00,
		FSB_FETCH_ONE = 2'b01,
		FSB_FETCH_TWO = 2'b10
	} fsb_fetch_e;

	typedef enum logic [1:0] {
		FSB_SLOT_FIRST = 2'b00,
		FSB_SLOT_SECOND = 2'b01,
		FSB_SLOT_FULL = 2'b10
	} fsb_slot_e;
endpackage

// File: core/fsb_scan_if.sv
// Interface carrying one prepared search field from the top to the priority scanner.
interface fsb_scan_if;
	logic [15:0] field;
	logic found;
	logic [3:0] pos;
	modport requester (output field, input found, input pos);
	modport scanner (input field, output found, output pos);
endinterface

// File: core/fsb_scan.sv
// Priority scanner: lowest set bit of a 16-bit field.
module fsb_scan (
	fsb_scan_if.scanner scan
);
	import fsb_pkg::*;

	logic [3:0] next_pos;

	// Walk from the top down so the lowest set bit is written last and wins.
	always_comb begin
		next_pos = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (scan.field[i]) begin
				next_pos = 4'(i);
			end
		end
	end

	assign scan.found = |scan.field;
	assign scan.pos = next_pos;
endmodule

// File: core/fsb_finder.sv
// First set bit finder: operand shaping, search counter, two lockable result registers.
`include "fsb_cfg.svh"

module fsb_finder (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_rst,
	// Search issue from the pipeline.
	input wire logic i_search_valid,
	input wire logic [31:0] i_search_operand,
	input wire logic [4:0] i_search_shift,
	input wire logic i_search_masked,
	input wire logic [31:0] i_search_mask,
	input wire logic i_search_clear,
	// Result fetch from the pipeline.
	input wire fsb_pkg::fsb_fetch_e i_fetch_sel,
	// Immediate data back to the ALU.
	output logic o_fetch_valid,
	output fsb_pkg::fsb_word_t o_fetch_data,
	// Result registers, for observation.
	output fsb_pkg::fsb_word_t o_outcome_first,
	output fsb_pkg::fsb_word_t o_outcome_second
);
	import fsb_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Stage one: register the search so the scan sees a clean field.

	logic s1_valid;
	logic s1_clear;
	logic [15:0] s1_field;
	logic [31:0] shifted_word;
	logic [31:0] mask_word;
	logic [15:0] next_field;

	// The shift picks any 16-bit window of the operand.
	assign shifted_word = i_search_operand >> i_search_shift;
	// Mask is whatever the ALU passed, register or immediate alike.
	assign mask_word = i_search_masked ? (i_search_mask >> i_search_shift) : 32'hffff_ffff;
	assign next_field = shifted_word[15:0] & mask_word[15:0];

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			s1_valid <= 1'b0;
			s1_clear <= 1'b0;
			s1_field <= 16'h0000;
		end else begin
			s1_valid <= i_search_valid;
			s1_clear <= i_search_valid & i_search_clear;
			s1_field <= next_field;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Scan.

	fsb_scan_if scan_bus ();
	assign scan_bus.field = s1_field;

	fsb_scan u_scan (
		.scan(scan_bus)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Stage two: counter and result registers.

	fsb_count_t count;
	fsb_word_t outcome_first;
	fsb_word_t outcome_second;
	fsb_count_t eff_count;
	logic eff_lock_first;
	logic eff_lock_second;
	fsb_slot_e target_slot;
	logic hit;
	fsb_word_t new_word;
	fsb_word_t next_first;
	fsb_word_t next_second;
	fsb_count_t next_count;

	// Clear acts before this search is counted, so its own hit gets index 0.
	assign eff_count = s1_clear ? `FSB_COUNT_RESET : count;
	assign eff_lock_first = s1_clear ? 1'b0 : outcome_first[`FSB_LOCK_BIT];
	assign eff_lock_second = s1_clear ? 1'b0 : outcome_second[`FSB_LOCK_BIT];

	// Empty field is no hit; it touches no result unless the same search clears.
	assign hit = s1_valid & scan_bus.found;

	// First free register wins; with both locked the hit goes nowhere.
	assign target_slot = !eff_lock_first ? FSB_SLOT_FIRST :
		(!eff_lock_second ? FSB_SLOT_SECOND : FSB_SLOT_FULL);

	// Upper bits are zero, lock flag, index, position.
	assign new_word = {23'h000000, 1'b1, eff_count, scan_bus.pos};

	// Hit loads and locks; a locked word is never rewritten until a clear.
	assign next_first = (hit && target_slot == FSB_SLOT_FIRST) ? new_word :
		(s1_clear ? `FSB_RESULT_RESET : outcome_first);
	assign next_second = (hit && target_slot == FSB_SLOT_SECOND) ? new_word :
		(s1_clear ? `FSB_RESULT_RESET : outcome_second);

	// Every search counts, hit or miss, and 15 rolls to 0.
	assign next_count = s1_valid ? fsb_count_t'(eff_count + 4'h1) : count;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			count <= `FSB_COUNT_RESET;
			outcome_first <= `FSB_RESULT_RESET;
			outcome_second <= `FSB_RESULT_RESET;
		end else begin
			count <= next_count;
			outcome_first <= next_first;
			outcome_second <= next_second;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fetch path: apart from the observation outputs, results leave only as immediate data on request.
	// The reader must keep the documented gap after a search; a fetch issued
	// sooner simply sees the older contents, nothing stalls.

	logic fetch_hit;
	fsb_word_t fetch_sel_word;

	assign fetch_hit = (i_fetch_sel == FSB_FETCH_ONE) || (i_fetch_sel == FSB_FETCH_TWO);
	assign fetch_sel_word = (i_fetch_sel == FSB_FETCH_TWO) ? outcome_second : outcome_first;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_fetch_valid <= 1'b0;
			o_fetch_data <= `FSB_RESULT_RESET;
		end else begin
			o_fetch_valid <= fetch_hit;
			o_fetch_data <= fetch_hit ? fetch_sel_word : `FSB_RESULT_RESET;
		end
	end

	assign o_outcome_first = outcome_first;
	assign o_outcome_second = outcome_second;
endmodule

// File: sim/fsb_chk_properties.sv
// Concurrent checks on the finder ports.
module fsb_chk (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_rst,
	// Requests.
	input wire logic i_search_valid,
	input wire logic [31:0] i_search_operand,
	input wire logic [4:0] i_search_shift,
	input wire logic i_search_masked,
	input wire logic i_search_clear,
	input wire fsb_pkg::fsb_fetch_e i_fetch_sel,
	// Results.
	input wire logic o_fetch_valid,
	input wire fsb_pkg::fsb_word_t o_fetch_data,
	input wire fsb_pkg::fsb_word_t o_outcome_first,
	input wire fsb_pkg::fsb_word_t o_outcome_second
);
	timeunit 1ns;
	timeprecision 1ps;
	import fsb_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	wire clr_req = i_search_valid && i_search_clear;
	wire hit_low = clr_req && !i_search_masked && i_search_operand == 32'h1 && i_search_shift == 5'h0;
	wire miss = i_search_valid && !i_search_clear && i_search_operand == 32'h0;
	////////////////////////////////
	rsv_zero_a: assert property ({o_outcome_first[31:9], o_outcome_second[31:9]} == 46'h0)
		else $error("reserved bits set");
	fetch_one_a: assert property (i_fetch_sel == FSB_FETCH_ONE
		|=> o_fetch_valid && o_fetch_data == $past(o_outcome_first)) else $error("fetch one");
	fetch_two_a: assert property (i_fetch_sel == FSB_FETCH_TWO
		|=> o_fetch_valid && o_fetch_data == $past(o_outcome_second)) else $error("fetch two");
	fetch_none_a: assert property (!(i_fetch_sel inside {FSB_FETCH_ONE, FSB_FETCH_TWO})
		|=> !o_fetch_valid && o_fetch_data == 32'h0) else $error("idle fetch");
	lock_hold_a: assert property ($past(o_outcome_first[8]) && !$past(clr_req, 2)
		|-> $stable(o_outcome_first)) else $error("locked result moved");
	second_order_a: assert property (o_outcome_second[8] |-> o_outcome_first[8])
		else $error("second locked alone");
	clear_both_a: assert property (clr_req |-> ##2 o_outcome_second == 32'h0 &&
		o_outcome_first[7:4] == 4'h0) else $error("clear failed");
	low_hit_a: assert property (hit_low |-> ##2 o_outcome_first == 32'h0000_0100)
		else $error("bit 0 hit wrong");
	miss_keep_a: assert property (miss |-> ##2 $stable(o_outcome_first) &&
		$stable(o_outcome_second)) else $error("miss changed result");
	cover property (o_outcome_second[8]);
	cover property (hit_low);
	cover property (o_fetch_valid);
endmodule
bind fsb_finder fsb_chk fsb_chk_search_index (.*);

// File: sim/fsb_pipe.sv
// Pipeline model issuing search and fetch instructions to the finder.
module fsb_pipe (
	// Clock.
	input wire logic i_mclk,
	// Requests.
	output logic o_valid,
	output logic [31:0] o_operand,
	output logic [4:0] o_shift,
	output logic o_masked,
	output logic [31:0] o_mask,
	output logic o_clear,
	output fsb_pkg::fsb_fetch_e o_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	import fsb_pkg::*;
	initial begin
		{o_valid, o_operand, o_shift, o_masked, o_mask, o_clear} = '0;
		o_sel = FSB_FETCH_NONE;
	end
	task automatic search(input logic [31:0] op, input logic [4:0] sh, input logic clr,
		input logic msk = 1'b0, input logic [31:0] mk = 32'h0);
		@(posedge i_mclk);
		#1;
		{o_valid, o_operand, o_shift, o_clear, o_masked, o_mask} = {1'b1, op, sh, clr, msk, mk};
	endtask
	// Idle slots keep the fetch clear of a search still in flight; operand is scrambled then.
	task automatic fetch(input fsb_fetch_e s);
		repeat (4) begin
			@(posedge i_mclk);
			#1;
			o_valid = 1'b0;
			o_operand = ~o_operand;
		end
		o_sel = s;
		@(posedge i_mclk);
		#1;
		o_sel = FSB_FETCH_NONE;
	endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the first set bit finder.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fsb_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic sv, sm, sc, fv;
	logic [31:0] so, sk;
	logic [4:0] ss;
	fsb_fetch_e sel;
	fsb_word_t fd, r1, r2;
	int bad_count = 0;
	int check_count = 0;
	initial begin
		forever #5 i_mclk = ~i_mclk;
	end
	fsb_pipe pm (.i_mclk, .o_valid(sv), .o_operand(so), .o_shift(ss), .o_masked(sm),
		.o_mask(sk), .o_clear(sc), .o_sel(sel));
	fsb_finder fsb_finder_search_index (.i_mclk, .i_rst, .i_search_valid(sv), .i_search_operand(so),
		.i_search_shift(ss), .i_search_masked(sm), .i_search_mask(sk), .i_search_clear(sc),
		.i_fetch_sel(sel), .o_fetch_valid(fv), .o_fetch_data(fd), .o_outcome_first(r1),
		.o_outcome_second(r2));
	////////////////////////////////
	task automatic chk(input fsb_fetch_e s, input fsb_word_t exp);
		pm.fetch(s);
		check_count++;
		if (fv !== 1'b1 || fd !== exp) begin
			bad_count++;
			$display("[ERR] fetch %0d exp valid 1 data %h seen valid %b data %h", s, exp, fv, fd);
		end
	endtask
	// Code 3 is refused like an idle slot; the result words themselves must still stand.
	task automatic t_refuse;
		pm.fetch(fsb_fetch_e'(2'b11));
		check_count++;
		if (fv !== 1'b0 || fd !== 32'h0) begin
			bad_count++;
			$display("[ERR] refused fetch exp valid 0 data 0 seen valid %b data %h", fv, fd);
		end
		check_count++;
		if (r1 !== 32'h0000_0100 || r2 !== 32'h0) begin
			bad_count++;
			$display("[ERR] outcome words exp 00000100 00000000 seen %h %h", r1, r2);
		end
	endtask
	task automatic final_report;
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic t_chain;
		pm.search(32'h0, 5'h0, 1'b1);
		pm.search(32'h0008_0000, 5'h10, 1'b0);
		pm.search(32'h0000_ffff, 5'h0, 1'b0, 1'b1, 32'h0000_00f0);
		pm.search(32'h1, 5'h0, 1'b0);
		chk(FSB_FETCH_ONE, 32'h0000_0113);
		chk(FSB_FETCH_TWO, 32'h0000_0124);
	endtask
	// Misses still advance the counter, so the 32'h8000 field lands on index 15 and the last field wraps to index 0.
	task automatic t_wrap;
		pm.search(32'h0, 5'h0, 1'b1);
		repeat (14) pm.search(32'h0, 5'h0, 1'b0);
		pm.search(32'h8000, 5'h0, 1'b0);
		pm.search(32'h1, 5'h0, 1'b0);
		chk(FSB_FETCH_ONE, 32'h0000_01ff);
		chk(FSB_FETCH_TWO, 32'h0000_0100);
	endtask
	task automatic t_clrhit;
		pm.search(32'h1, 5'h0, 1'b1);
		chk(FSB_FETCH_ONE, 32'h0000_0100);
		chk(FSB_FETCH_TWO, 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge i_mclk);
		#1;
		i_rst = 1'b0;
		t_chain;
		t_wrap;
		t_clrhit;
		t_refuse;
		final_report;
	end
endmodule
